// [rtl/buck_seq_pkg.sv]
/*
 * Constants and state encodings shared by the converter sequencing logic.
 * Assumes one 200 MHz system clock and comparator results already synchronous to it.
 */
package buck_seq_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int PERIOD_NS = 5;
	localparam int RAMP_TIME_US = 3;
	localparam int RAMP_TIMEOUT_US = 5;
	localparam int HICCUP_WAIT_US = 50;
	localparam int RAMP_TIME_CYC = RAMP_TIME_US * CLK_MHZ;
	localparam int RAMP_TIMEOUT_CYC = RAMP_TIMEOUT_US * CLK_MHZ;
	localparam int HICCUP_WAIT_CYC = HICCUP_WAIT_US * CLK_MHZ;
	localparam int LOW_OUT_LIMIT = 128;
	localparam int BOOT_CHARGE_CYC = 4;

	// ----------------------------------------------------------------
	// switching period and dither
	// ----------------------------------------------------------------
	localparam logic [9:0] NOMINAL_PERIOD = 10'h064;
	localparam logic [9:0] SPREAD_SPAN = 10'h002;
	localparam logic [9:0] SLOWED_PERIOD = 10'h0C8;
	localparam logic [9:0] DITHER_STEP = 10'h001;
	localparam int LFSR_W = 31;
	localparam logic [30:0] LFSR_SEED = 31'h00000001;

	// ----------------------------------------------------------------
	// reference scale
	// ----------------------------------------------------------------
	localparam int REF_W = 12;
	localparam logic [11:0] REF_FULL = 12'hFFF;
	localparam logic [11:0] REF_ZERO = 12'h000;
	localparam logic [11:0] REF_PRESET_OFS = 12'h029;
	localparam logic [11:0] REF_STEP = 12'h007;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_RAMP = 5'h02,
		ST_RUN = 5'h04,
		ST_RECOVER = 5'h08,
		ST_HICCUP = 5'h10
	} seq_state_e;

endpackage

// [rtl/buck_softstart_spread_control.sv]
/*
 * Sequencing for a synchronous step-down converter: boot recharge, soft start,
 * hiccup, dropout recovery and spread-spectrum qualification.
 * Assumes comparator inputs are synchronous to clk; raw pin inputs pass two flops.
 */
// Functional notes
// R01 - boot below threshold: turn on low side first, then high side
// R02 - spread spectrum present only when factory option is set
// R03 - dithered frequency stays within plus or minus two percent
// R04 - hop every cycle from LFSR, limited step between cycles
// R05 - whole dither pattern repeats slower than 1.5 Hz
// R06 - spread off when clock slowed or synchronised externally
// R07 - forced fixed-frequency mode keeps spread on even at no load
// R08 - soft start on lockout release, enable, hiccup end, thermal recovery
// R09 - reference ramps so output reaches 90 percent within ramp time
// R10 - soft start forces auto mode with diode emulation
// R11 - fixed-frequency and hiccup disabled until regulation or ramp timeout
// R12 - output a few percent low enters dropout recovery with slow ramp
// R13 - recovery presets reference one percent above present output level
// R14 - hiccup inhibited while regulating in dropout
// R15 - recovery: output under 0.4 for over 128 cycles triggers hiccup
// R16 - fixed-frequency mode stays allowed during dropout recovery
// R17 - recovery ramp rate equals start-up ramp rate
// R18 - hiccup stops switching, waits, then retries with soft start
// R19 - analog side gives clock-aligned comparator results
`timescale 1ns/1ps

module buck_softstart_spread_control #(
	parameter int HICCUP_WAIT_CYCLES = buck_seq_pkg::HICCUP_WAIT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// raw pins and events
	input wire logic enablePin,
	input wire logic uvloReleased,
	input wire logic thermalOk,
	// configuration
	input wire logic spreadOption,
	input wire logic forcedFixedFreqMode,
	input wire logic lightLoadSlow,
	input wire logic minOnTimeSlow,
	input wire logic dropoutSlow,
	input wire logic extSyncLocked,
	// comparators, clock aligned
	input wire logic bootUnderVolt,
	input wire logic outBelowFortyPct,
	input wire logic outInReg,
	input wire logic outFewPctLow,
	input wire logic [11:0] outLevel,
	input wire logic highSideReq,
	// outputs
	output logic highSideOn,
	output logic lowSideOn,
	output logic switchingOn,
	output logic [11:0] refLevel,
	output logic diodeEmulation,
	output logic fixedFreqActive,
	output logic hiccupEnabled,
	output logic spreadActive,
	output logic cycleTick,
	output logic [9:0] period
);

	buck_seq_pkg::seq_state_e state_reg;
	buck_seq_pkg::seq_state_e state_next;
	logic [1:0] enSync_reg;
	logic [1:0] uvloSync_reg;
	logic [1:0] tempSync_reg;
	logic enPrev_reg;
	logic uvloPrev_reg;
	logic tempPrev_reg;
	logic startEvent;
	logic [15:0] timer_reg;
	logic [7:0] lowCount_reg;
	logic [2:0] bootCount_reg;
	logic bootCharging_reg;
	logic rampDone;
	logic spreadAllowed;
	logic ditherTick;
	logic [9:0] ditherPeriod;
	logic runUp;

	// saturating reference step shared by ramp and recovery
	function automatic logic [11:0] ref_step(input logic [11:0] cur);
		if (cur >= buck_seq_pkg::REF_FULL - buck_seq_pkg::REF_STEP) begin
			ref_step = buck_seq_pkg::REF_FULL;
		end else begin
			ref_step = cur + buck_seq_pkg::REF_STEP;
		end
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and start events
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			enSync_reg <= 2'h0;
			uvloSync_reg <= 2'h0;
			tempSync_reg <= 2'h0;
			enPrev_reg <= 1'b0;
			uvloPrev_reg <= 1'b0;
			tempPrev_reg <= 1'b0;
		end else begin
			enSync_reg <= {enSync_reg[0], enablePin};
			uvloSync_reg <= {uvloSync_reg[0], uvloReleased};
			tempSync_reg <= {tempSync_reg[0], thermalOk};
			enPrev_reg <= enSync_reg[1];
			uvloPrev_reg <= uvloSync_reg[1];
			tempPrev_reg <= tempSync_reg[1];
		end
	end

	// a rising edge on any gate starts a ramp once all three gates are high
	assign runUp = enSync_reg[1] && uvloSync_reg[1] && tempSync_reg[1];
	assign startEvent = runUp && ((enSync_reg[1] && !enPrev_reg)
		|| (uvloSync_reg[1] && !uvloPrev_reg) || (tempSync_reg[1] && !tempPrev_reg)); // R08
	assign rampDone = outInReg || (timer_reg >= 16'(buck_seq_pkg::RAMP_TIMEOUT_CYC));

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			buck_seq_pkg::ST_OFF: begin
				if (startEvent) begin
					state_next = buck_seq_pkg::ST_RAMP; // R08
				end
			end
			buck_seq_pkg::ST_RAMP: begin
				if (rampDone) begin
					state_next = buck_seq_pkg::ST_RUN; // R11
				end
			end
			buck_seq_pkg::ST_RUN: begin
				if (outFewPctLow) begin
					state_next = buck_seq_pkg::ST_RECOVER; // R12
				end
			end
			buck_seq_pkg::ST_RECOVER: begin
				if (lowCount_reg >= 8'(buck_seq_pkg::LOW_OUT_LIMIT)) begin
					state_next = buck_seq_pkg::ST_HICCUP; // R15
				end else if (refLevel == buck_seq_pkg::REF_FULL) begin
					state_next = buck_seq_pkg::ST_RUN;
				end
			end
			buck_seq_pkg::ST_HICCUP: begin
				if (timer_reg >= 16'(HICCUP_WAIT_CYCLES)) begin
					state_next = buck_seq_pkg::ST_RAMP; // R08 R18
				end
			end
			default: state_next = buck_seq_pkg::ST_OFF;
		endcase
		if (!runUp) begin
			state_next = buck_seq_pkg::ST_OFF;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= buck_seq_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// timer restarts on each state change
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timer_reg <= 16'h0000;
		end else if (state_next != state_reg) begin
			timer_reg <= 16'h0000;
		end else if (timer_reg != 16'hFFFF) begin
			timer_reg <= timer_reg + 16'h0001;
		end
	end

	// low-output counter, only in recovery and not in dropout
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lowCount_reg <= 8'h00;
		end else if (state_reg == buck_seq_pkg::ST_RECOVER && outBelowFortyPct
			&& !dropoutSlow) begin // R14
			if (lowCount_reg != 8'hFF) begin
				lowCount_reg <= lowCount_reg + 8'h01; // R15
			end
		end else begin
			lowCount_reg <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// reference ramp
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			refLevel <= buck_seq_pkg::REF_ZERO;
		end else if (state_reg == buck_seq_pkg::ST_OFF || state_reg == buck_seq_pkg::ST_HICCUP) begin
			refLevel <= buck_seq_pkg::REF_ZERO;
		end else if (state_reg == buck_seq_pkg::ST_RUN && state_next == buck_seq_pkg::ST_RECOVER) begin
			refLevel <= ref_step(outLevel + buck_seq_pkg::REF_PRESET_OFS - buck_seq_pkg::REF_STEP); // R13
		end else if (state_reg == buck_seq_pkg::ST_RAMP || state_reg == buck_seq_pkg::ST_RECOVER) begin
			refLevel <= ref_step(refLevel); // R09 R17
		end else begin
			refLevel <= buck_seq_pkg::REF_FULL;
		end
	end

	// ------------------------------------------------------------
	// mode outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			diodeEmulation <= 1'b1;
			fixedFreqActive <= 1'b0;
			hiccupEnabled <= 1'b0;
			switchingOn <= 1'b0;
		end else begin
			diodeEmulation <= (state_next == buck_seq_pkg::ST_RAMP) || !forcedFixedFreqMode; // R10
			fixedFreqActive <= forcedFixedFreqMode && (state_next == buck_seq_pkg::ST_RUN
				|| state_next == buck_seq_pkg::ST_RECOVER); // R11 R16
			hiccupEnabled <= !dropoutSlow && (state_next == buck_seq_pkg::ST_RUN
				|| state_next == buck_seq_pkg::ST_RECOVER); // R11 R14
			switchingOn <= state_next == buck_seq_pkg::ST_RAMP || state_next == buck_seq_pkg::ST_RUN
				|| state_next == buck_seq_pkg::ST_RECOVER; // R18
		end
	end

	// ------------------------------------------------------------
	// boot recharge ahead of high side
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bootCharging_reg <= 1'b0;
			bootCount_reg <= 3'h0;
			highSideOn <= 1'b0;
			lowSideOn <= 1'b0;
		end else if (!switchingOn) begin
			bootCharging_reg <= 1'b0;
			bootCount_reg <= 3'h0;
			highSideOn <= 1'b0;
			lowSideOn <= 1'b0;
		end else if (highSideReq && (bootUnderVolt || bootCharging_reg)) begin
			bootCharging_reg <= bootCount_reg < 3'(buck_seq_pkg::BOOT_CHARGE_CYC - 1); // R01
			bootCount_reg <= bootCount_reg + 3'h1;
			highSideOn <= 1'b0;
			lowSideOn <= 1'b1; // R01
		end else begin
			bootCharging_reg <= 1'b0;
			bootCount_reg <= 3'h0;
			highSideOn <= highSideReq;
			lowSideOn <= !highSideReq;
		end
	end

	// ------------------------------------------------------------
	// spread spectrum
	// ------------------------------------------------------------
	assign spreadAllowed = spreadOption && !extSyncLocked && !dropoutSlow && !minOnTimeSlow
		&& (forcedFixedFreqMode || !lightLoadSlow); // R02 R06 R07

	spread_dither ditherGen (
		.clk(clk),
		.rst_n(rst_n),
		.spreadOn(spreadAllowed),
		.slowClock(dropoutSlow || minOnTimeSlow || (!forcedFixedFreqMode && lightLoadSlow)),
		.cycleStart(ditherTick),
		.periodNow(ditherPeriod)
	);

	// registered spread outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			spreadActive <= 1'b0;
			cycleTick <= 1'b0;
			period <= buck_seq_pkg::NOMINAL_PERIOD;
		end else begin
			spreadActive <= spreadAllowed; // R06
			cycleTick <= ditherTick;
			period <= ditherPeriod;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence boot_low_req;
		switchingOn && highSideReq && bootUnderVolt;
	endsequence

	chk_boot_first: assert property (@(posedge clk) disable iff (!rst_n) // R01
		boot_low_req |=> (lowSideOn && !highSideOn))
		else $error("high side before boot recharge");

	chk_spread_gate: assert property (@(posedge clk) disable iff (!rst_n) // R06
		(extSyncLocked || dropoutSlow || !spreadOption) |=> !spreadActive)
		else $error("spread active while gated");

	chk_forced_fixed_freq_mode_spread: assert property (@(posedge clk) disable iff (!rst_n) // R07
		(spreadOption && forcedFixedFreqMode && !extSyncLocked && !dropoutSlow && !minOnTimeSlow)
		|=> spreadActive)
		else $error("spread off in forced mode");

	chk_start_ramp: assert property (@(posedge clk) disable iff (!rst_n) // R08
		(state_reg == buck_seq_pkg::ST_OFF && startEvent) |=> state_reg == buck_seq_pkg::ST_RAMP)
		else $error("start event missed");

	chk_ramp_modes: assert property (@(posedge clk) disable iff (!rst_n) // R10
		(state_reg == buck_seq_pkg::ST_RAMP) |-> (diodeEmulation && !fixedFreqActive
		&& !hiccupEnabled))
		else $error("ramp modes wrong");

	chk_ramp_end: assert property (@(posedge clk) disable iff (!rst_n) // R11
		(state_reg == buck_seq_pkg::ST_RAMP && outInReg && runUp) |=>
		state_reg == buck_seq_pkg::ST_RUN)
		else $error("ramp did not end on regulation");

	chk_hiccup_count: assert property (@(posedge clk) disable iff (!rst_n) // R15
		(lowCount_reg == 8'h80 && state_reg == buck_seq_pkg::ST_RECOVER && runUp) |=>
		state_reg == buck_seq_pkg::ST_HICCUP)
		else $error("hiccup not taken");

	chk_hiccup_stop: assert property (@(posedge clk) disable iff (!rst_n) // R18
		(state_reg == buck_seq_pkg::ST_HICCUP) |=> !switchingOn || state_reg != buck_seq_pkg::ST_HICCUP)
		else $error("switching in hiccup");

endmodule

// [rtl/spread_dither.sv]
/*
 * Switching period generator with LFSR dithering of the period.
 * Assumes enables come from logic on the same clock.
 */
`timescale 1ns/1ps

module spread_dither (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic spreadOn,
	input wire logic slowClock,
	// outputs
	output logic cycleStart,
	output logic [9:0] periodNow
);

	logic [30:0] lfsr_reg;
	logic [9:0] count_reg;
	logic [9:0] period_reg;
	logic [9:0] target;
	logic inBand;

	// ------------------------------------------------------------
	// target period: slowed period, nominal with spread off, else from the LFSR inside the spread band
	// ------------------------------------------------------------
	always_comb begin
		if (slowClock) begin
			target = buck_seq_pkg::SLOWED_PERIOD;
		end else if (!spreadOn) begin
			target = buck_seq_pkg::NOMINAL_PERIOD;
		end else if (lfsr_reg[0]) begin
			target = buck_seq_pkg::NOMINAL_PERIOD + buck_seq_pkg::SPREAD_SPAN; // R03
		end else begin
			target = buck_seq_pkg::NOMINAL_PERIOD - buck_seq_pkg::SPREAD_SPAN; // R03
		end
	end

	// 31-bit maximal LFSR, steps once per cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lfsr_reg <= buck_seq_pkg::LFSR_SEED;
		end else if (cycleStart && spreadOn) begin
			lfsr_reg <= {lfsr_reg[29:0], lfsr_reg[30] ^ lfsr_reg[27]}; // R05
		end
	end

	// a period left over from a slowed clock is reloaded, not walked back step by step
	assign inBand = period_reg <= buck_seq_pkg::NOMINAL_PERIOD + buck_seq_pkg::SPREAD_SPAN
		&& period_reg >= buck_seq_pkg::NOMINAL_PERIOD - buck_seq_pkg::SPREAD_SPAN;

	// period moves one step at a time toward target while dithering in band, else loads target
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			period_reg <= buck_seq_pkg::NOMINAL_PERIOD;
		end else if (cycleStart) begin
			if (slowClock || !spreadOn || !inBand) begin // R06
				period_reg <= target;
			end else if (period_reg < target) begin
				period_reg <= period_reg + buck_seq_pkg::DITHER_STEP; // R04
			end else if (period_reg > target) begin
				period_reg <= period_reg - buck_seq_pkg::DITHER_STEP; // R04
			end
		end
	end

	// period counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= 10'h000;
			cycleStart <= 1'b0;
		end else if (count_reg >= period_reg - 10'h001) begin
			count_reg <= 10'h000;
			cycleStart <= 1'b1;
		end else begin
			count_reg <= count_reg + 10'h001;
			cycleStart <= 1'b0;
		end
	end

	assign periodNow = period_reg;

	// period stays inside band while dithering
	chk_period_band: assert property (@(posedge clk) disable iff (!rst_n) // R03
		($past(cycleStart) && $past(spreadOn) && !$past(slowClock))
		|-> (period_reg <= buck_seq_pkg::NOMINAL_PERIOD + buck_seq_pkg::SPREAD_SPAN
		&& period_reg + buck_seq_pkg::SPREAD_SPAN >= buck_seq_pkg::NOMINAL_PERIOD))
		else $error("period outside spread band");

	chk_hop_step: assert property (@(posedge clk) disable iff (!rst_n) // R04
		($past(cycleStart) && $past(spreadOn) && !$past(slowClock) && $past(inBand))
		|-> (period_reg - $past(period_reg) <= buck_seq_pkg::DITHER_STEP
		|| $past(period_reg) - period_reg <= buck_seq_pkg::DITHER_STEP))
		else $error("period hop too large");

endmodule

// [tb/power_stage_model.sv]
/*
 * Behavioural power stage and comparators facing the sequencer.
 * Assumes the bench changes sag and boot-drain commands at the falling edge.
 */
`timescale 1ns/1ps

module power_stage_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// from the sequencer
	input wire logic switchingOn,
	input wire logic lowSideOn,
	input wire logic [11:0] refLevel,
	// bench commands
	input wire logic sagOn,
	input wire logic [11:0] sagLevel,
	input wire logic bootDrain,
	// comparator results
	output logic bootUnderVolt,
	output logic outBelowFortyPct,
	output logic outInReg,
	output logic outFewPctLow,
	output logic [11:0] outLevel
);
	localparam logic [11:0] REG_LEVEL = 12'hF5C;
	localparam logic [11:0] FORTY_PCT = 12'h666;
	logic [1:0] chargeCnt;

	// output tracks the reference unless a sag is imposed
	always_ff @(posedge clk) begin
		if (!rst_n || (!switchingOn && !sagOn)) begin
			outLevel <= 12'h000;
		end else if (sagOn) begin
			outLevel <= sagLevel;
		end else begin
			outLevel <= refLevel;
		end
	end

	// boot cap recovers after three low-side cycles
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bootUnderVolt <= 1'b0;
			chargeCnt <= 2'h0;
		end else if (bootDrain) begin
			bootUnderVolt <= 1'b1;
			chargeCnt <= 2'h0;
		end else if (bootUnderVolt && lowSideOn) begin
			chargeCnt <= chargeCnt + 2'h1;
			bootUnderVolt <= (chargeCnt != 2'h2);
		end
	end

	// comparators read the registered level, so they stay clock aligned
	assign outBelowFortyPct = outLevel < FORTY_PCT;
	assign outInReg = outLevel >= REG_LEVEL;
	assign outFewPctLow = switchingOn && (outLevel < REG_LEVEL);
endmodule

// [tb/tb_top.sv]
/*
 * Self-checking bench for the converter sequencer with a power stage model.
 * Assumes the hiccup wait is shortened to 20 cycles.
 */
`timescale 1ns/1ps

module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] gates = 3'b011;
	logic spreadOption = 1'b1;
	logic forcedFixedFreqMode = 1'b1;
	logic [3:0] slows = 4'h0;
	logic highSideReq = 1'b0;
	logic sagOn = 1'b0;
	logic [11:0] sagLevel = 12'h500;
	logic bootDrain = 1'b0;
	logic bootUnderVolt, outBelowFortyPct, outInReg, outFewPctLow;
	logic [11:0] outLevel, refLevel;
	logic highSideOn, lowSideOn, switchingOn, diodeEmulation;
	logic fixedFreqActive, hiccupEnabled, spreadActive, cycleTick;
	logic [9:0] period;
	int fail_count = 0;
	int checks = 0;
	int cycleCount = 0;

	always #2.5 clk = ~clk;

	buck_softstart_spread_control #(.HICCUP_WAIT_CYCLES(20)) u_buck_softstart_spread_control (
		.clk(clk), .rst_n(rst_n), .enablePin(gates[2]), .uvloReleased(gates[1]),
		.thermalOk(gates[0]), .spreadOption(spreadOption),
		.forcedFixedFreqMode(forcedFixedFreqMode), .lightLoadSlow(slows[0]),
		.minOnTimeSlow(slows[1]), .dropoutSlow(slows[2]), .extSyncLocked(slows[3]),
		.bootUnderVolt(bootUnderVolt), .outBelowFortyPct(outBelowFortyPct),
		.outInReg(outInReg), .outFewPctLow(outFewPctLow), .outLevel(outLevel),
		.highSideReq(highSideReq), .highSideOn(highSideOn), .lowSideOn(lowSideOn),
		.switchingOn(switchingOn), .refLevel(refLevel), .diodeEmulation(diodeEmulation),
		.fixedFreqActive(fixedFreqActive), .hiccupEnabled(hiccupEnabled),
		.spreadActive(spreadActive), .cycleTick(cycleTick), .period(period));

	power_stage_model u_power_stage_model (
		.clk(clk), .rst_n(rst_n), .switchingOn(switchingOn), .lowSideOn(lowSideOn),
		.refLevel(refLevel), .sagOn(sagOn), .sagLevel(sagLevel), .bootDrain(bootDrain),
		.bootUnderVolt(bootUnderVolt), .outBelowFortyPct(outBelowFortyPct),
		.outInReg(outInReg), .outFewPctLow(outFewPctLow), .outLevel(outLevel));

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		if (fail_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [11:0] got, input logic [11:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// one gate dropped and raised again, then a full ramp into run
	task automatic start_via(input int idx);
		int n;
		logic [11:0] r0;
		logic [11:0] ninety;
		ninety = 12'(buck_seq_pkg::REF_FULL * 9 / 10);
		gates[idx] = 1'b0;
		settle(8);
		check(switchingOn, 1'b0, "switching with a gate low");
		gates[idx] = 1'b1;
		for (n = 0; n < 10 && switchingOn !== 1'b1; n++) @(negedge clk);
		check(switchingOn, 1'b1, "soft start not begun");
		check(diodeEmulation, 1'b1, "no diode emulation in ramp");
		r0 = refLevel;
		settle(100);
		check(refLevel, r0 + 12'(buck_seq_pkg::REF_STEP * 100), "ramp slope");
		check(fixedFreqActive, 1'b0, "fixed freq in ramp");
		check(hiccupEnabled, 1'b0, "hiccup armed in ramp");
		for (n = 100; n < buck_seq_pkg::RAMP_TIME_CYC && refLevel < ninety; n++) @(negedge clk);
		check(refLevel >= ninety, 1'b1, "ninety percent not reached in ramp time");
		for (n = 0; n < 1100 && refLevel !== 12'hFFF; n++) @(negedge clk);
		settle(2);
		check(fixedFreqActive, 1'b1, "fixed freq after ramp");
		check(hiccupEnabled, 1'b1, "hiccup not armed after ramp");
	endtask

	// dither band, hop size, and each override
	task automatic spread_check();
		int n;
		int k;
		int moves;
		logic [9:0] prev;
		moves = 0;
		prev = period;
		check(spreadActive, 1'b1, "spread off in fixed freq run");
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			for (k = 0; k < 200 && cycleTick !== 1'b1; k++) @(negedge clk);
			check(period >= buck_seq_pkg::NOMINAL_PERIOD - buck_seq_pkg::SPREAD_SPAN &&
				period <= buck_seq_pkg::NOMINAL_PERIOD + buck_seq_pkg::SPREAD_SPAN, 1'b1,
				"period out of band");
			check(period - prev + 10'h001 <= 10'h002, 1'b1, "hop too large");
			if (period !== prev) moves++;
			prev = period;
		end
		check(moves > 0, 1'b1, "period never hops");
		for (n = 0; n < 4; n++) begin
			slows[n] = 1'b1;
			settle(110);
			if (n == 0) begin
				check(spreadActive, 1'b1, "spread lost at light load in forced mode");
				forcedFixedFreqMode = 1'b0;
				settle(110);
			end
			check(spreadActive, 1'b0, "spread kept while slowed");
			forcedFixedFreqMode = 1'b1;
			slows[n] = 1'b0;
			settle(110);
		end
		spreadOption = 1'b0;
		settle(110);
		check(spreadActive, 1'b0, "spread without option");
		spreadOption = 1'b1;
	endtask

	// boot recharge precedes high side
	task automatic boot_check();
		int n;
		bootDrain = 1'b1;
		settle(1);
		bootDrain = 1'b0;
		settle(1);
		highSideReq = 1'b1;
		settle(1);
		check({highSideOn, lowSideOn}, 2'b01, "low side not first");
		for (n = 0; n < 12 && highSideOn !== 1'b1; n++) @(negedge clk);
		check({highSideOn, lowSideOn}, 2'b10, "high side not reached");
		highSideReq = 1'b0;
	endtask

	// dropout recovery, hiccup on low output, retry
	task automatic recover_check();
		int n;
		slows[2] = 1'b1;
		sagOn = 1'b1;
		for (n = 0; n < 10 && refLevel === 12'hFFF; n++) @(negedge clk);
		check(refLevel, sagLevel + buck_seq_pkg::REF_PRESET_OFS, "recovery preset");
		settle(1);
		check(refLevel, sagLevel + buck_seq_pkg::REF_PRESET_OFS + buck_seq_pkg::REF_STEP,
			"recovery slope");
		check(fixedFreqActive, 1'b1, "fixed freq lost in recovery");
		settle(200);
		check(switchingOn, 1'b1, "hiccup in dropout");
		slows[2] = 1'b0;
		settle(127);
		check(switchingOn, 1'b1, "hiccup too early");
		for (n = 0; n < 12 && switchingOn !== 1'b0; n++) @(negedge clk);
		check(switchingOn, 1'b0, "no hiccup on low output");
		sagOn = 1'b0;
		settle(15);
		check({switchingOn, highSideOn, lowSideOn}, 3'b000, "switching in hiccup wait");
		for (n = 0; n < 30 && switchingOn !== 1'b1; n++) @(negedge clk);
		check(switchingOn, 1'b1, "no retry after hiccup");
		check(hiccupEnabled, 1'b0, "hiccup armed in retry");
	endtask

	// ----------------------------------------------------------------
	// main sequence and timeout
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(negedge clk);
		check({highSideOn, lowSideOn, switchingOn, diodeEmulation, fixedFreqActive,
			hiccupEnabled, spreadActive, cycleTick}, 8'h10, "reset outputs");
		check(period, buck_seq_pkg::NOMINAL_PERIOD, "reset period");
		rst_n = 1'b1;
		settle(2);
		for (int i = 2; i >= 0; i--) start_via(i);
		spread_check();
		boot_check();
		recover_check();
		tally_and_finish();
	end

	always @(posedge clk) begin
		cycleCount++;
		if (cycleCount == 12000) begin
			fail_count++;
			tally_and_finish();
		end
	end
endmodule
